// ==== logic/board_watchdog_timer.v ====
// Purpose: Board watchdog timer retriggered by ISA I/O accesses.
// Assumes: ISA strobes arrive synchronous to i_mclk; straps are static.
// Notes:   Expiry is routed to reset or NMI and held until reinitialised.
// Notes:   The super I/O watchdog only supplies the expiry; routing stays here.
`timescale 1ns/1ps
`include "wdt_map.vh"
module board_watchdog_timer (
  input  wire                    i_mclk,
  input  wire                    i_sys_rst,
  input  wire                    i_watchdog_enable_strap,
  input  wire                    i_port_select_strap,
  input  wire                    i_expiry_route_strap,
  input  wire                    i_timeout_source_strap,
  input  wire [2:0]              i_interval_select_strap,
  input  wire [15:0]             i_io_addr,
  input  wire                    i_io_wr,
  input  wire [7:0]              i_io_wdata,
  input  wire                    i_superio_timeout,
  input  wire                    i_reinit,
  output reg                     o_sys_reset,
  output reg                     o_nmi,
  output reg                     o_expired,
  output reg                     o_running,
  output reg  [7:0]              o_sw_interval
);

  // ****************************************
  // Port decode
  // ****************************************
  // Only writes are decoded; the port pair in use follows the port strap
  function port_hit;
    input [15:0] addr;
    input        alt;
    begin
      port_hit = 1'b0;
      if (!alt && (addr == `WDT_PORT_A_DEF)) begin
        port_hit = 1'b1;                                                     // [R7]
      end else if (!alt && (addr == `WDT_PORT_B_DEF)) begin
        port_hit = 1'b1;                                                     // [R7]
      end else if (alt && (addr == `WDT_PORT_A_ALT)) begin
        port_hit = 1'b1;                                                     // [R7]
      end else if (alt && (addr == `WDT_PORT_B_ALT)) begin
        port_hit = 1'b1;                                                     // [R7]
      end
    end
  endfunction

  // Strap time in half-second ticks: two to the n, 0.5 s up to 64 s
  function [`WDT_CNT_W-1:0] strap_ticks;
    input [2:0] n;
    begin
      case (n)
        3'h0:    strap_ticks = 16'h0001;
        3'h1:    strap_ticks = 16'h0002;
        3'h2:    strap_ticks = 16'h0004;
        3'h3:    strap_ticks = 16'h0008;
        3'h4:    strap_ticks = 16'h0010;
        3'h5:    strap_ticks = 16'h0020;
        3'h6:    strap_ticks = 16'h0040;
        default: strap_ticks = 16'h0080;
      endcase
    end
  endfunction

  // Software value v gives (v - 0.5) minutes; 255 still fits the 16-bit counter
  // Value zero never reaches this function, it selects the strap time instead
  function [`WDT_CNT_W-1:0] soft_ticks;
    input [7:0]  v;
    reg   [31:0] t;
    begin
      t          = v * `WDT_SW_STEP_TICKS - `WDT_SW_OFFS_TICKS;
      soft_ticks = t[`WDT_CNT_W-1:0];
    end
  endfunction

  // ****************************************
  // Access qualification
  // ****************************************
  wire                  enabled;
  wire                  addr_hit;
  wire                  retrigger;
  wire                  sw_load;
  wire                  live;
  wire                  tick;
  wire                  board_expire;
  wire                  expire;
  wire                  fire;
  wire                  route_nmi;
  wire [`WDT_CNT_W-1:0] load_value;
  reg  [`WDT_CNT_W-1:0] cnt_q;
  reg  [`WDT_CNT_W-1:0] cnt_d;

  assign enabled   = i_watchdog_enable_strap;                             // [R2]
  assign addr_hit  = port_hit(i_io_addr, !i_port_select_strap);           // [R7]
  // Writes are refused while disabled, latched in expiry or being reinitialised
  assign retrigger = enabled && !o_expired && !i_reinit && i_io_wr && addr_hit;
  // A nonzero byte selects software minutes; zero returns to the strap time
  assign sw_load   = retrigger && (i_io_wdata != 8'h00);
  // Counting goes on only while armed, unexpired and not being reinitialised
  assign live      = enabled && o_running && !o_expired && !i_reinit;     // [R1]

  // ****************************************
  // Interval selection
  // ****************************************
  assign load_value = sw_load ? soft_ticks(i_io_wdata)                     // [R8]
                              : strap_ticks(i_interval_select_strap);      // [R5]

  // ****************************************
  // Half-second time base
  // ****************************************
  // Phase restarts on each retrigger so the interval is exact to one cycle
  // The divider idles while stopped, so no stale phase survives a restart
  wdt_tick_div u_div (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_run     (o_running),
    .i_clr     (retrigger),
    .o_tick    (tick)
  );

  // ****************************************
  // Expiry source and routing
  // ****************************************
  // A loaded value of n expires on the n-th half-second tick after the retrigger
  assign board_expire = tick && (cnt_q == 16'h0001);
  // The super I/O input may be a pulse or a level: expiry latches on its first cycle
  assign expire       = (i_timeout_source_strap == `WDT_SRC_SUPERIO) ?
                        i_superio_timeout : board_expire;                 // [R6]
  // A retrigger in the same cycle beats an expiry: last-moment software still wins
  assign fire         = live && !retrigger && expire;
  // Default strap position routes to reset
  assign route_nmi    = (i_expiry_route_strap == `WDT_ROUTE_NMI);

  // ****************************************
  // Down counter
  // ****************************************
  always @* begin
    cnt_d = cnt_q;
    if (!enabled) begin
      cnt_d = {`WDT_CNT_W{1'b0}};                                          // [R2]
    end else if (retrigger) begin
      cnt_d = load_value;                                                  // [R9]
    end else if (fire) begin
      cnt_d = {`WDT_CNT_W{1'b0}};
    end else if (live && tick) begin
      cnt_d = cnt_q - 1'b1;                                                // [R1]
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= {`WDT_CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // Run and expiry state
  // ****************************************
  // Running starts with the first accepted retrigger and stops on expiry,
  // reinitialisation or a shorted enable strap
  // Straps are read every cycle; moving one while running takes effect at once, except the interval strap, which is only loaded on a retrigger
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_running <= 1'b0;
    end else if (!enabled || i_reinit || o_expired) begin
      o_running <= 1'b0;                                                   // [R2] [R9]
    end else if (retrigger) begin
      o_running <= 1'b1;                                                   // [R1]
    end
  end

  // Expiry latches until reinitialised; a shorted enable strap clears it as well
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_expired <= 1'b0;
    end else if (!enabled || i_reinit) begin
      o_expired <= 1'b0;                                                   // [R9]
    end else if (fire) begin
      o_expired <= 1'b1;
    end
  end

  // ****************************************
  // Expiry outputs
  // ****************************************
  // Route is taken from the strap at the moment of expiry and then held
  // Both outputs clear together, so reset and NMI are never high at once
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sys_reset <= 1'b0;
    end else if (!enabled || i_reinit) begin
      o_sys_reset <= 1'b0;                                                 // [R9]
    end else if (fire) begin
      o_sys_reset <= !route_nmi;                                           // [R3]
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nmi <= 1'b0;
    end else if (!enabled || i_reinit) begin
      o_nmi <= 1'b0;                                                       // [R9]
    end else if (fire) begin
      o_nmi <= route_nmi;                                                  // [R4]
    end
  end

  // ****************************************
  // Software interval readback
  // ****************************************
  // Holds the last accepted byte; zero means the strap interval is in force
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sw_interval <= 8'h00;
    end else if (retrigger) begin
      o_sw_interval <= i_io_wdata;                                         // [R8]
    end
  end

endmodule

// ==== shared/wdt_map.vh ====
// Purpose: Constants for the board watchdog timer.
// Assumes: 40 MHz system clock; straps are static levels, 1 = open, 0 = shorted.
// Notes:   Times are held in their printed unit; WDT_BASE_CYCLES derives from them, but WDT_BASE_LAST is written as a literal.
// Notes on behaviour
// [R1] Watchdog runs only when armed; host must retrigger it before it expires.
// [R2] Enable strap open enables the watchdog; shorted disables it fully, the default.
// [R3] Routing strap in default position: expiry asserts system reset.
// [R4] Routing strap in alternate position: expiry asserts NMI instead of reset.
// [R5] Interval strap value n selects 0.5 s times two to the n; 1 s default.
// [R6] Source strap picks board timer (default) or super I/O watchdog as time-out source.
// [R7] Port strap open decodes 0533H/0033H; shorted decodes 0543H/0343H.
// [R8] Software mode offers 255 intervals in one-minute steps, 0.5 to 254.5 minutes.
// [R9] Retrigger reloads full interval; expiry output holds until reinitialised.
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

`define WDT_CLK_HZ          40000000
// Base period of 0.5 s, expressed in milliseconds
`define WDT_BASE_MS         500
`define WDT_BASE_CYCLES     (`WDT_CLK_HZ / 1000 * `WDT_BASE_MS)
// Last count of the half-second divider, sized to the divider counter
`define WDT_BASE_LAST       25'h1312CFF
// Software value v selects (v - 0.5) minutes, counted in half-second ticks
`define WDT_SW_STEP_TICKS   120
`define WDT_SW_OFFS_TICKS   60

`define WDT_PORT_A_DEF      16'h0533
`define WDT_PORT_B_DEF      16'h0033
`define WDT_PORT_A_ALT      16'h0543
`define WDT_PORT_B_ALT      16'h0343

`define WDT_ROUTE_RESET     1'b0
`define WDT_ROUTE_NMI       1'b1
`define WDT_SRC_BOARD       1'b0
`define WDT_SRC_SUPERIO     1'b1

`define WDT_CNT_W           16
`define WDT_TICK_W          25

`endif

// ==== logic/wdt_tick_div.v ====
// Purpose: Divider giving a one-cycle pulse every half second.
// Assumes: Single clock; i_clr restarts the phase.
// Notes:   Restarting on retrigger keeps the interval exact to one cycle.
`timescale 1ns/1ps
`include "wdt_map.vh"
module wdt_tick_div (
  input  wire                    i_mclk,
  input  wire                    i_sys_rst,
  input  wire                    i_run,
  input  wire                    i_clr,
  output reg                     o_tick
);
  localparam [`WDT_TICK_W-1:0] LAST = `WDT_BASE_LAST;
  reg [`WDT_TICK_W-1:0] cnt_q;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q  <= {`WDT_TICK_W{1'b0}};
      o_tick <= 1'b0;
    end else if (i_clr || !i_run) begin
      cnt_q  <= {`WDT_TICK_W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= {`WDT_TICK_W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

// ==== verif/wdt_props.sv ====
// Purpose: Port assertions for the board watchdog.
// Assumes: Straps stay static while the watchdog is armed.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
module wdt_props (
  input wire        i_mclk, i_sys_rst, i_watchdog_enable_strap, i_port_select_strap,
  input wire        i_expiry_route_strap, i_timeout_source_strap, i_io_wr, i_reinit,
  input wire        i_superio_timeout, o_sys_reset, o_nmi, o_expired, o_running,
  input wire [2:0]  i_interval_select_strap,
  input wire [15:0] i_io_addr,
  input wire [7:0]  i_io_wdata, o_sw_interval
);
  wire en = i_watchdog_enable_strap;
  wire hit = i_port_select_strap ? (i_io_addr == 16'h0533 || i_io_addr == 16'h0033)
                                 : (i_io_addr == 16'h0543 || i_io_addr == 16'h0343);
  wire acc = i_io_wr && hit && en && !o_expired && !i_reinit;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_off; !en |=> !o_running && !o_sys_reset && !o_nmi; endproperty
  a_off: assert property (p_off) else $error("disabled but active");
  property p_rst; $rose(o_expired) && !i_expiry_route_strap |-> o_sys_reset && !o_nmi; endproperty
  a_rst: assert property (p_rst) else $error("reset route wrong");
  property p_nmi; $rose(o_expired) && i_expiry_route_strap |-> o_nmi && !o_sys_reset; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi route wrong");
  property p_hold; o_expired && en && !i_reinit |=> o_expired; endproperty
  a_hold: assert property (p_hold) else $error("expiry dropped");
  property p_clr; i_reinit |=> !o_expired && !o_sys_reset && !o_nmi; endproperty
  a_clr: assert property (p_clr) else $error("reinit ignored");
  property p_acc; acc |=> o_running ##1 o_running; endproperty
  a_acc: assert property (p_acc) else $error("retrigger not taken");
  property p_sw; acc |=> o_sw_interval == $past(i_io_wdata); endproperty
  a_sw: assert property (p_sw) else $error("software value wrong");
  property p_src; i_timeout_source_strap && i_superio_timeout && o_running && en && !o_expired
    && !i_reinit && !acc |=> o_expired; endproperty
  a_src: assert property (p_src) else $error("super io expiry lost");
  c_rst: cover property (o_sys_reset);
  c_nmi: cover property (o_nmi);
  c_acc: cover property (acc);
endmodule

// ==== verif/isa_host.sv ====
// Purpose: Host software model writing the watchdog ports.
// Assumes: Requests launch on the falling edge, one cycle each.
// Notes:   A released address bus shows the inverse pattern, never the last value.
`timescale 1ns/1ps
module isa_host (
  input  wire        i_mclk,
  output reg  [15:0] o_addr = 16'hFFFF,
  output reg         o_wr = 1'b0,
  output reg  [7:0]  o_data = 8'h00
);
  task wr(input [15:0] a, input [7:0] d); begin
    @(negedge i_mclk);
    o_addr = a;
    o_data = d;
    o_wr = 1'b1;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_data = ~d;
  end endtask
endmodule

// ==== verif/tb_board_watchdog_timer.sv ====
// Purpose: Self-checking bench for the board watchdog.
// Assumes: Expiry is forced through the super I/O input.
// Notes:   The half-second board tick is too long to reach in this run.
`timescale 1ns/1ps
module tb_board_watchdog_timer;
  reg clk = 0, rst = 1, en = 0, ps = 1, rt = 0, src = 0, sio = 0, ri = 0;
  reg [2:0] iv = 3'h1;
  reg [7:0] e = 8'h00;
  reg [15:0] a;
  integer seed = 48609, n_mismatch = 0, tests_run = 0, i, r;
  wire [15:0] ad;
  wire [7:0] wd, sw;
  wire wr, sr, nm, ex, rn;
  always #12.5 clk = ~clk;
  isa_host h (.i_mclk(clk), .o_addr(ad), .o_wr(wr), .o_data(wd));
  board_watchdog_timer dut (.i_mclk(clk), .i_sys_rst(rst), .i_watchdog_enable_strap(en),
    .i_port_select_strap(ps), .i_expiry_route_strap(rt), .i_timeout_source_strap(src),
    .i_interval_select_strap(iv), .i_io_addr(ad), .i_io_wr(wr), .i_io_wdata(wd),
    .i_superio_timeout(sio), .i_reinit(ri), .o_sys_reset(sr), .o_nmi(nm),
    .o_expired(ex), .o_running(rn), .o_sw_interval(sw));
  task chk(input [7:0] s, x); begin
    tests_run = tests_run + 1;
    if (s !== x) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t seen %h want %h", $time, s, x);
    end
  end endtask
  task final_report; begin
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  function hit(input [15:0] x, input p);
    hit = p ? (x == 16'h0533 || x == 16'h0033) : (x == 16'h0543 || x == 16'h0343);
  endfunction
  // Reinit also stops the watchdog so each write starts from idle
  task step; begin
    @(negedge clk) ri = 1;
    @(negedge clk) ri = 0;
  end endtask
  initial begin
    #200000 n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    chk({4'h0, ex, sr, nm, rn}, 8'h00);
    chk(sw, 8'h00);
    h.wr(16'h0533, 8'h05);
    @(negedge clk) chk(rn, 0);
    chk(sw, 8'h00);
    en = 1;
    for (i = 0; i < 24; i = i + 1) begin
      r = $random(seed);
      ps = r[4];
      iv = r[2:0];
      a = r[7] ? r[31:16] : {4'h0, r[6] ? 4'h5 : (r[5] ? 4'h3 : 4'h0), r[5] ? 4'h4 : 4'h3, 4'h3};
      step;
      h.wr(a, r[15:8]);
      if (hit(a, ps)) e = r[15:8];
      @(negedge clk) chk(rn, hit(a, ps));
      chk(sw, e);
    end
    src = 1;
    for (i = 0; i < 2; i = i + 1) begin
      rt = i[0];
      step;
      h.wr(ps ? 16'h0033 : 16'h0343, 8'h00);
      @(negedge clk) sio = 1;
      @(negedge clk) sio = 0;
      @(negedge clk) chk({ex, sr, nm}, {1'b1, ~rt, rt});
      h.wr(ps ? 16'h0533 : 16'h0543, 8'hA5);
      chk(sw, 8'h00);
      step;
      chk({ex, sr, nm}, 3'h0);
    end
    // Reset in mid-run must clear a running watchdog and its readback
    h.wr(ps ? 16'h0533 : 16'h0543, 8'h07);
    @(negedge clk) rst = 1;
    @(negedge clk) rst = 0;
    chk({4'h0, ex, sr, nm, rn}, 8'h00);
    chk(sw, 8'h00);
    h.wr(ps ? 16'h0033 : 16'h0343, 8'h09);
    @(negedge clk) chk(rn, 1);
    chk(sw, 8'h09);
    final_report;
  end
endmodule
bind board_watchdog_timer wdt_props chk_i (.*);
